// ### design/wdtu_pkg.sv
// Package with register map, field positions, reset values and timing counts of the watchdog unit
package wdtu_pkg;

    // Register indices; byte address on APB is four times the index
    localparam logic [15:0] IDX_PROC_MODE_ONE   = 16'h0005;
    localparam logic [15:0] IDX_VMON_TWO_CTRL   = 16'h002c;
    localparam logic [15:0] IDX_CSP_CONTROL     = 16'h037c;
    localparam logic [15:0] IDX_WDT_REFRESH     = 16'h037d;
    localparam logic [15:0] IDX_WDT_START       = 16'h037e;
    localparam logic [15:0] IDX_WDT_CONTROL     = 16'h037f;
    localparam logic [15:0] IDX_BOOT_OPTION     = 16'hffff;

    // Smallest address width that reaches the highest index
    localparam int          MIN_ADDR_W          = 18;

    // Field positions
    localparam int          PM1_ACTION_BIT      = 2;
    localparam int          BOOT_START_BIT      = 0;
    localparam int          BOOT_PROTECT_BIT    = 7;
    localparam int          CSP_ENABLE_BIT      = 7;
    localparam int          WDC_PRESCALE_BIT    = 7;
    localparam int          WDC_COUNT_BITS      = 5;

    // Refresh sequence bytes
    localparam logic [7:0]  REFRESH_FIRST       = 8'h00;
    localparam logic [7:0]  REFRESH_SECOND      = 8'hff;

    // Reset values
    localparam logic [7:0]  PM1_RESET           = 8'h00;
    localparam logic [7:0]  VOLTAGE_MONITOR_TWO_CONTROL_RESET          = 8'h00;
    localparam logic [7:0]  BOOT_RESET          = 8'hff;
    localparam logic [31:0] RDATA_RESET         = 32'h0000_0000;

    // Prescaler limits for the counter tick; the tick period is one cycle more, 16 or 128 cycles
    localparam logic [6:0]  PRESCALE_SHORT      = 7'h0f;
    localparam logic [6:0]  PRESCALE_LONG       = 7'h7f;

    typedef enum logic [0:0] {
        RF_IDLE,
        RF_ARMED
    } wdtu_refresh_t;

endpackage : wdtu_pkg

// ### design/wdtu_cnt_if.sv
// Interface between the watchdog control logic and its down counter
`timescale 1ns/100ps
`default_nettype none
interface wdtu_cnt_if #(
    parameter int CW = 15
);
    logic          tick;
    logic          reload;
    logic          run;
    logic [CW-1:0] count;
    logic          underflow;

    modport ctl (output tick, output reload, output run, input count, input underflow);
    modport cnt (input tick, input reload, input run, output count, output underflow);
endinterface : wdtu_cnt_if
`default_nettype wire

// ### design/wdtu_counter.sv
// Watchdog down counter with reload and underflow pulse
`timescale 1ns/100ps
`default_nettype none
module wdtu_counter #(
    parameter int CW = 15
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    wdtu_cnt_if.cnt     cbus
);
    import wdtu_pkg::*;

    localparam logic [CW-1:0] FULL = {CW{1'b1}};

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic          uf_q;
    logic          uf_d;

    always_comb begin
        count_d = count_q;
        uf_d    = 1'b0;
        if (cbus.reload) begin
            count_d = FULL;
        end else if (cbus.run && cbus.tick) begin
            if (count_q == '0) begin
                count_d = FULL;
                uf_d    = 1'b1;
            end else begin
                count_d = count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= FULL;
            uf_q    <= 1'b0;
        end else begin
            count_q <= count_d;
            uf_q    <= uf_d;
        end
    end

    assign cbus.count     = count_q;
    assign cbus.underflow = uf_q;
endmodule : wdtu_counter
`default_nettype wire

// ### design/wdtu_top.sv
// Watchdog timer unit with APB register slave, refresh sequence, boot strap and underflow action
//
// Behaviour
// - An underflow of the counter raises either a watchdog interrupt request or a chip reset request.
// - Bit 2 of the processor mode register picks the action: 0 gives the interrupt, 1 gives the reset.
// - Besides a start from stop, only a write of 00h followed by a write of ffh to the refresh register reloads the counter.
// - Any write to the start register with pstrb bit 0 set starts the counter whatever the data.
// - Boot option bit 0 at reset release starts counting automatically when 0 and leaves it stopped when 1.
`timescale 1ns/100ps
`default_nettype none
module wdtu_top #(
    parameter int AW = 18,
    parameter int CW = 15
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    input  wire logic [7:0]    boot_option_in,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               wdt_irq_req,
    output logic               wdt_rst_req,
    output logic               wdt_running
);
    import wdtu_pkg::*;

    // Refuse parameter values the decode or the status field cannot serve
    generate
        if (AW < MIN_ADDR_W || AW > 32) begin : g_bad_aw
            $error("Address width cannot reach the register map");
        end
        if (CW < WDC_COUNT_BITS || CW > 24) begin : g_bad_cw
            $error("Counter width out of range");
        end
    endgenerate

    // Down counter lives in its own module behind the counter interface
    wdtu_cnt_if #(.CW(CW)) cbus ();

    wdtu_counter #(.CW(CW)) u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cbus    (cbus.cnt)
    );

    // ---------------- APB slave ----------------
    logic [15:0]   idx;
    logic          aligned;
    logic          mapped;
    logic          setup;
    logic          wr_en;
    logic [7:0]    wbyte;
    logic [31:0]   rdata_sel;

    logic [31:0]   prdata_q;
    logic [31:0]   prdata_d;
    logic          pready_q;
    logic          pready_d;
    logic          pslverr_q;
    logic          pslverr_d;

    assign idx     = 16'(paddr[AW-1:2]);
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[AW-1:2] == (AW-2)'(idx));
    assign setup   = psel && !penable && !pready_q;
    assign wbyte   = pwdata[7:0];
    // Write lands at the access edge where pready is seen high
    assign wr_en   = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];

    // ---------------- Register and control state ----------------
    logic [7:0]    pm1_q;
    logic [7:0]    pm1_d;
    logic [7:0]    voltage_monitor_two_control_q;
    logic [7:0]    voltage_monitor_two_control_d;
    logic [7:0]    boot_q;
    logic [7:0]    boot_d;
    logic          strap_taken_q;
    logic          strap_taken_d;
    logic          prot_q;
    logic          prot_d;
    logic          pre_sel_q;
    logic          pre_sel_d;
    logic          run_q;
    logic          run_d;
    logic          reload;
    // Refresh sequence state
    wdtu_refresh_t rf_q;
    wdtu_refresh_t rf_d;
    // Underflow action pulses
    logic          irq_q;
    logic          irq_d;
    logic          rst_q;
    logic          rst_d;

    // Prescaler state
    logic [6:0]    pre_q;
    logic [6:0]    pre_d;
    logic [6:0]    pre_lim;
    logic          tick;

    // Unmapped or misaligned accesses are refused here and never reach the register state
    // Address decode and read data for the setup cycle
    always_comb begin
        mapped    = 1'b1;
        rdata_sel = RDATA_RESET;
        case (idx)
            IDX_PROC_MODE_ONE: rdata_sel[7:0] = pm1_q;
            IDX_VMON_TWO_CTRL: rdata_sel[7:0] = voltage_monitor_two_control_q;
            IDX_CSP_CONTROL:   rdata_sel[CSP_ENABLE_BIT] = prot_q;
            IDX_WDT_REFRESH:   rdata_sel = RDATA_RESET;
            IDX_WDT_START:     rdata_sel = RDATA_RESET;
            IDX_WDT_CONTROL: begin
                rdata_sel[WDC_PRESCALE_BIT]    = pre_sel_q;
                rdata_sel[WDC_COUNT_BITS-1:0]  = cbus.count[CW-1 -: WDC_COUNT_BITS];
            end
            IDX_BOOT_OPTION:   rdata_sel[7:0] = boot_q;
            default:           mapped = 1'b0;
        endcase
        if (!aligned) begin
            mapped = 1'b0;
        end
    end

    // Read data is latched at setup so it still stands after the access ends
    // One wait-free access: pready rises in the access phase after every setup
    always_comb begin
        pready_d  = setup;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            pslverr_d = !mapped;
            prdata_d  = (mapped && !pwrite) ? rdata_sel : RDATA_RESET;
        end else if (pready_q) begin
            pslverr_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= RDATA_RESET;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // The strap is taken once, at the first edge after reset release; later pin changes are ignored
    // Strap capture, registers, start and refresh sequence
    always_comb begin
        pm1_d         = pm1_q;
        voltage_monitor_two_control_d        = voltage_monitor_two_control_q;
        boot_d        = boot_q;
        strap_taken_d = 1'b1;
        prot_d        = prot_q;
        pre_sel_d     = pre_sel_q;
        run_d         = run_q;
        rf_d          = rf_q;
        reload        = 1'b0;
        if (!strap_taken_q) begin
            boot_d = boot_option_in;
            if (!boot_option_in[BOOT_START_BIT]) begin
                run_d  = 1'b1;
                reload = 1'b1;
            end
            if (!boot_option_in[BOOT_PROTECT_BIT]) begin
                prot_d = 1'b1;
            end
        end
        if (wr_en) begin
            case (idx)
                IDX_PROC_MODE_ONE: pm1_d = wbyte;
                IDX_VMON_TWO_CTRL: voltage_monitor_two_control_d = wbyte;
                IDX_CSP_CONTROL: begin
                    if (wbyte[CSP_ENABLE_BIT]) begin
                        prot_d = 1'b1;
                    end
                end
                IDX_WDT_CONTROL: begin
                    // Protection locks the prescaler choice
                    if (!prot_q) begin
                        pre_sel_d = wbyte[WDC_PRESCALE_BIT];
                    end
                end
                IDX_WDT_START: begin
                    // A start while running keeps the count, so it cannot stand in for a refresh
                    if (!run_q) begin
                        reload = 1'b1;
                    end
                    run_d = 1'b1;
                end
                default: ;
            endcase
            // Writes elsewhere leave the sequence armed; a second 00h keeps it armed
            if (idx == IDX_WDT_REFRESH) begin
                case (rf_q)
                    RF_IDLE: begin
                        rf_d = (wbyte == REFRESH_FIRST) ? RF_ARMED : RF_IDLE;
                    end
                    RF_ARMED: begin
                        if (wbyte == REFRESH_SECOND) begin
                            reload = 1'b1;
                            rf_d   = RF_IDLE;
                        end else if (wbyte == REFRESH_FIRST) begin
                            rf_d = RF_ARMED;
                        end else begin
                            rf_d = RF_IDLE;
                        end
                    end
                    default: rf_d = RF_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm1_q         <= PM1_RESET;
            voltage_monitor_two_control_q        <= VOLTAGE_MONITOR_TWO_CONTROL_RESET;
            boot_q        <= BOOT_RESET;
            strap_taken_q <= 1'b0;
            prot_q        <= 1'b0;
            pre_sel_q     <= 1'b0;
            run_q         <= 1'b0;
            rf_q          <= RF_IDLE;
        end else begin
            pm1_q         <= pm1_d;
            voltage_monitor_two_control_q        <= voltage_monitor_two_control_d;
            boot_q        <= boot_d;
            strap_taken_q <= strap_taken_d;
            prot_q        <= prot_d;
            pre_sel_q     <= pre_sel_d;
            run_q         <= run_d;
            rf_q          <= rf_d;
        end
    end

    // Prescaler: one tick pulse per divided period; protection ticks every cycle
    // Restart on stop, reload and tick so the first period after a start is a full one
    assign pre_lim = pre_sel_q ? PRESCALE_LONG : PRESCALE_SHORT;
    assign tick    = prot_q || (pre_q >= pre_lim);

    always_comb begin
        pre_d = pre_q;
        if (!run_q || reload || tick) begin
            pre_d = 7'h00;
        end else begin
            pre_d = pre_q + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 7'h00;
        end else begin
            pre_q <= pre_d;
        end
    end

    // Tick is a clock enable, one cycle per period or every cycle under protection; the counter never sees a second clock
    assign cbus.tick   = tick;
    assign cbus.run    = run_q;
    assign cbus.reload = reload;

    // Underflow action
    // The mode bit is read at the underflow itself, so a late change still takes effect
    always_comb begin
        irq_d = 1'b0;
        rst_d = 1'b0;
        if (cbus.underflow) begin
            if (pm1_q[PM1_ACTION_BIT]) begin
                rst_d = 1'b1;
            end else begin
                irq_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            rst_q <= rst_d;
        end
    end

    // All outputs come straight from flip-flops
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign wdt_irq_req = irq_q;
    assign wdt_rst_req = rst_q;
    assign wdt_running = run_q;
endmodule : wdtu_top
`default_nettype wire

// ### test/wdtu_top_assertions.sv
// Concurrent checks on the watchdog unit ports
`timescale 1ns/100ps
`default_nettype none
module wdtu_top_assertions
    import wdtu_pkg::*;
#(
    parameter int AW = 18,
    parameter int CW = 15
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [7:0]    boot_option_in,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          wdt_irq_req,
    input wire logic          wdt_rst_req,
    input wire logic          wdt_running
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic req = wdt_irq_req || wdt_rst_req;

    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no pready after setup");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
    property p_refuse; pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
    property p_hi_zero; pready |-> prdata[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
    property p_boot_run; $rose(presetn) && !boot_option_in[0] |-> ##[1:2] wdt_running; endproperty
    a_boot_run: assert property (p_boot_run) else $error("no auto start");
    property p_boot_stop; $rose(presetn) && boot_option_in[0] |=> !wdt_running [*2]; endproperty
    a_boot_stop: assert property (p_boot_stop) else $error("started while strapped off");
    property p_start;
        psel && penable && pready && pwrite && pstrb[0] && paddr == {IDX_WDT_START, 2'b00} |=> wdt_running;
    endproperty
    a_start: assert property (p_start) else $error("start write ignored");
    property p_keep_run; wdt_running |=> wdt_running; endproperty
    a_keep_run: assert property (p_keep_run) else $error("counter stopped");
    property p_req_run; req |-> $past(wdt_running, 2) ##1 !req; endproperty
    a_req_run: assert property (p_req_run) else $error("bad underflow request");
    property p_one_req; !(wdt_irq_req && wdt_rst_req); endproperty
    a_one_req: assert property (p_one_req) else $error("both actions at once");
endmodule // wdtu_top_assertions
bind wdtu_top wdtu_top_assertions #(.AW(AW), .CW(CW)) wdtu_top_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .boot_option_in(boot_option_in),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq_req(wdt_irq_req),
    .wdt_rst_req(wdt_rst_req), .wdt_running(wdt_running)
);
`default_nettype wire

// ### test/wdtu_top_tb.sv
// Self-checking testbench of the watchdog unit
`timescale 1ns/100ps
`default_nettype none
module wdtu_top_tb;
    import wdtu_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'h1;
    logic [7:0]  boot_option_in = 8'hff;
    logic        pready, pslverr, wdt_irq_req, wdt_rst_req, wdt_running, err;
    int          errors = 0, n_compared = 0, n_irq = 0, n_rst = 0, bi, br;

    // Short counter keeps underflow times near a thousand cycles
    wdtu_top #(.AW(18), .CW(6)) wdtu_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .boot_option_in(boot_option_in),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq_req(wdt_irq_req),
        .wdt_rst_req(wdt_rst_req), .wdt_running(wdt_running)
    );
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (wdt_irq_req === 1'b1) n_irq <= n_irq + 1;
        if (wdt_rst_req === 1'b1) n_rst <= n_rst + 1;
    end

    task report_and_stop;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) begin
            errors++;
            $display("BAD %0t no pready", $time);
            report_and_stop;
        end
    endtask
    task do_reset(input logic [7:0] strap);
        @(posedge pclk);
        presetn <= 0; boot_option_in <= strap;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
    endtask
    task wait_req(input int lim);
        int n;
        n = 0;
        bi = n_irq; br = n_rst;
        while (n_irq + n_rst == bi + br && n < lim) begin @(posedge pclk); n++; end
        if (n_irq + n_rst == bi + br) begin
            errors++;
            $display("BAD %0t no underflow request", $time);
            report_and_stop;
        end
        repeat (4) @(posedge pclk);
    endtask

    task t_stopped;
        do_reset(8'hff);
        check(wdt_running, 0);
        apb(0, {IDX_BOOT_OPTION, 2'b00}, 0); check(rd, 32'hff);
        apb(0, {IDX_CSP_CONTROL, 2'b00}, 0); check(rd[7], 0);
        apb(0, {IDX_PROC_MODE_ONE, 2'b00}, 0); check(rd, 32'h0);
        apb(0, 18'h00010, 0); check(err, 1);
        apb(1, 18'h00015, 8'h5a); check(err, 1);
        apb(1, {IDX_VMON_TWO_CTRL, 2'b00}, 8'ha5);
        apb(0, {IDX_VMON_TWO_CTRL, 2'b00}, 0); check(rd, 32'ha5);
        pstrb <= 4'h0;
        apb(1, {IDX_PROC_MODE_ONE, 2'b00}, 8'h04);
        pstrb <= 4'h1;
        apb(0, {IDX_PROC_MODE_ONE, 2'b00}, 0); check(rd, 32'h0);
        apb(1, {IDX_WDT_CONTROL, 2'b00}, 8'h80);
        apb(0, {IDX_WDT_CONTROL, 2'b00}, 0); check(rd, 32'h9f);
        apb(1, {IDX_WDT_CONTROL, 2'b00}, 8'h00);
        apb(0, {IDX_WDT_REFRESH, 2'b00}, 0); check(rd, 32'h0);
        repeat (1200) @(posedge pclk);
        check(n_irq + n_rst, 0);
        apb(1, {IDX_WDT_START, 2'b00}, 8'h5a);
        repeat (2) @(posedge pclk);
        check(wdt_running, 1);
    endtask
    task t_refresh;
        bi = n_irq;
        repeat (600) @(posedge pclk);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, REFRESH_FIRST);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, REFRESH_FIRST);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, REFRESH_SECOND);
        repeat (700) @(posedge pclk);
        check(n_irq, bi);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, REFRESH_FIRST);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, 8'h12);
        apb(1, {IDX_WDT_REFRESH, 2'b00}, REFRESH_SECOND);
        wait_req(400);
        check(n_irq, bi + 1);
        check(n_rst, br);
    endtask
    task t_action;
        apb(1, {IDX_PROC_MODE_ONE, 2'b00}, 8'h04);
        apb(0, {IDX_PROC_MODE_ONE, 2'b00}, 0); check(rd, 32'h4);
        wait_req(1100);
        check(n_rst, br + 1);
        check(n_irq, bi);
        apb(1, {IDX_CSP_CONTROL, 2'b00}, 8'h80);
        apb(0, {IDX_CSP_CONTROL, 2'b00}, 0); check(rd[7], 1);
        apb(1, {IDX_WDT_CONTROL, 2'b00}, 8'h80);
        apb(0, {IDX_WDT_CONTROL, 2'b00}, 0); check(rd[7], 0);
        wait_req(100);
        check(n_rst, br + 1);
    endtask
    task t_autorun;
        do_reset(8'h7e);
        check(wdt_running, 1);
        apb(0, {IDX_CSP_CONTROL, 2'b00}, 0); check(rd[7], 1);
        wait_req(100);
        check(n_irq, bi + 1);
    endtask

    initial begin
        t_stopped;
        t_refresh;
        t_action;
        t_autorun;
        report_and_stop;
    end
endmodule // wdtu_top_tb
`default_nettype wire
